//--- design/umc_pkg.sv
// Notes on behaviour
// - bit 7: clock used undivided or divided by four
// - bit 6: normal serial or infrared encoding
// - bit 5: any-character resume enable
// - bit 4: internal loopback, tx to rx
// - bit 2: gates trigger level register access
// - bit 1 drives request-to-send low when set, outside loopback
// - automatic flow control overrides request-to-send bit
// - bit 0 drives terminal-ready when pin selected, outside loopback
// - bits 7:5 and 2 need enhanced write enable
// - status bit 7 is inverse carrier detect
// - status bit 6 is inverse ring input
// - status bit 5 is inverse data-set-ready, or bit 0 in loopback
// - status bit 4 inverse clear-to-send, or loopback
// - bits 3,1,0 latch changes, clear on read
// - bit 2 latches ring rising edge only
// - scratch byte freely written and read back
package umc_pkg;
    // register indices on the local port
    localparam logic [3:0] ADDR_MODEM_CTL = 4'h0;
    localparam logic [3:0] ADDR_MODEM_STAT = 4'h1;
    localparam logic [3:0] ADDR_SCRATCH = 4'h2;
    localparam logic [3:0] ADDR_IRQ_STAT = 4'h3;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'h4;
    // control register field positions
    localparam int CTL_PRESCALE = 7;
    localparam int CTL_IRDA = 6;
    localparam int CTL_XON_ANY = 5;
    localparam int CTL_LOOPBACK = 4;
    localparam int CTL_TRIG_EN = 2;
    localparam int CTL_RTS = 1;
    localparam int CTL_DTR = 0;
    // bits guarded by the enhanced write enable
    localparam logic [7:0] CTL_LOCKED_MASK = 8'he4;
    // bits always writable, reserved bit 3 excluded
    localparam logic [7:0] CTL_OPEN_MASK = 8'h13;
    // reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] SCRATCH_RESET = 8'h00;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    // prescale divide ratio when bit 7 is set
    localparam int PRESCALE_DIV = 4;
    // one bundle of the register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } umc_bus_req_s;
    // modem inputs as they arrive on the pins, active low
    typedef struct packed {
        logic cd_n;
        logic ri_n;
        logic dsr_n;
        logic cts_n;
    } umc_modem_in_s;
    // four event flags, layout shared by all event registers
    typedef struct packed {
        logic cd;
        logic ri;
        logic dsr;
        logic cts;
    } umc_event_s;
endpackage : umc_pkg

//--- design/umc_modem_ctl.sv
`timescale 1ns/100ps
module umc_modem_ctl #(
    parameter int PRESCALE_DIV = umc_pkg::PRESCALE_DIV
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset,
    // register port
    input wire umc_pkg::umc_bus_req_s i_bus,
    output logic [7:0] o_rdata,
    // neighbour uart logic, same clock
    input wire logic i_efr_wr_en,
    input wire logic i_auto_rts_en,
    input wire logic i_flow_rts_n,
    input wire logic i_tx_serial,
    input wire logic i_io_modem_sel,
    input wire logic i_gpio5_level,
    // modem pins, asynchronous
    input wire umc_pkg::umc_modem_in_s i_modem_n,
    input wire logic i_rx_pin,
    // modem and serial pin outputs
    output logic o_rts_n,
    output logic o_dtr_n,
    output logic o_tx_pin,
    // to the uart core
    output logic o_rx_serial,
    output logic o_clk_en,
    output logic o_irda_mode,
    output logic o_xon_any,
    output logic o_loopback,
    output logic o_trig_access_en,
    output logic [3:0] o_io_pin_view,
    // interrupt
    output logic o_irq
);

    // refuse ratios the counter cannot serve, caught at elaboration
    if (PRESCALE_DIV < 2) begin : g_bad_div
        $error("PRESCALE_DIV must be at least 2");
    end

    localparam int CW = $clog2(PRESCALE_DIV);
    localparam logic [CW-1:0] CNT_LAST = CW'(PRESCALE_DIV - 1);

    // decode helper used by the strobe decodes
    function automatic logic hit(input logic [3:0] a,
                                 input logic [3:0] idx);
        hit = (a == idx);
    endfunction : hit

    logic [7:0] ctl_r; // modem line control
    logic [7:0] scratch_r; // scratch byte
    logic [3:0] delta_r; // msr change flags
    logic [3:0] delta_nxt;
    logic [3:0] irq_stat_r; // sticky event status
    logic [3:0] irq_stat_nxt;
    logic [3:0] irq_mask_r; // interrupt enables
    logic [CW-1:0] pre_cnt_r; // prescale counter
    umc_pkg::umc_modem_in_s pin_s1_r; // first sync stage only
    umc_pkg::umc_modem_in_s pin_s2_r; // safe pin levels
    logic rx_s1_r;
    logic rx_s2_r;
    umc_pkg::umc_event_s lvl; // active-high live levels
    umc_pkg::umc_event_s lvl_prev_r; // levels one cycle ago
    umc_pkg::umc_event_s evt; // change events this cycle
    logic [7:0] msr_view; // status byte as read
    logic loop;
    logic wr_ctl, rd_stat, wr_scr, wr_istat, wr_imask;

    // strobe decodes
    assign wr_ctl = i_bus.wr && hit(i_bus.addr, umc_pkg::ADDR_MODEM_CTL);
    assign rd_stat = i_bus.rd && hit(i_bus.addr, umc_pkg::ADDR_MODEM_STAT);
    assign wr_scr = i_bus.wr && hit(i_bus.addr, umc_pkg::ADDR_SCRATCH);
    assign wr_istat = i_bus.wr && hit(i_bus.addr, umc_pkg::ADDR_IRQ_STAT);
    assign wr_imask = i_bus.wr && hit(i_bus.addr, umc_pkg::ADDR_IRQ_MASK);
    assign loop = ctl_r[umc_pkg::CTL_LOOPBACK];

    // control register write, guarded bits need the enable
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            ctl_r <= umc_pkg::CTL_RESET;
        end else if (wr_ctl) begin
            // open bits always take the write
            ctl_r <= (ctl_r & ~umc_pkg::CTL_OPEN_MASK)
                   | (i_bus.wdata & umc_pkg::CTL_OPEN_MASK);
            if (i_efr_wr_en) begin
                // locked bits only move while enabled
                ctl_r <= (i_bus.wdata
                          & (umc_pkg::CTL_OPEN_MASK
                             | umc_pkg::CTL_LOCKED_MASK));
            end
        end
    end

    // mode bits straight to the uart core
    assign o_irda_mode = ctl_r[umc_pkg::CTL_IRDA];
    assign o_xon_any = ctl_r[umc_pkg::CTL_XON_ANY];
    assign o_loopback = loop;
    assign o_trig_access_en = ctl_r[umc_pkg::CTL_TRIG_EN];

    // prescale counter, free running so the pulse is regular
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pre_cnt_r <= '0;
        end else if (pre_cnt_r == CNT_LAST) begin
            pre_cnt_r <= '0;
        end else begin
            pre_cnt_r <= pre_cnt_r + CW'(1);
        end
    end

    // every cycle undivided, one in four when prescaled
    assign o_clk_en = !ctl_r[umc_pkg::CTL_PRESCALE]
                      || (pre_cnt_r == CNT_LAST);

    // scratch byte, touches nothing else
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            scratch_r <= umc_pkg::SCRATCH_RESET;
        end else if (wr_scr) begin
            scratch_r <= i_bus.wdata;
        end
    end

    // two-stage synchronisers for the asynchronous pins
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
        end else begin
            pin_s1_r <= i_modem_n;
            pin_s2_r <= pin_s1_r;
            rx_s1_r <= i_rx_pin;
            rx_s2_r <= rx_s1_r;
        end
    end

    // live levels, pins inverted since they idle high
    always_comb begin
        lvl.cts = loop ? ctl_r[umc_pkg::CTL_RTS]
                       : !pin_s2_r.cts_n;
        // data-set-ready only when the shared pin is a modem pin
        lvl.dsr = loop ? ctl_r[umc_pkg::CTL_DTR]
                       : (i_io_modem_sel && !pin_s2_r.dsr_n);
        lvl.ri = i_io_modem_sel && !pin_s2_r.ri_n;
        lvl.cd = i_io_modem_sel && !pin_s2_r.cd_n;
    end

    // previous levels for change detection
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            lvl_prev_r <= '0;
        end else begin
            lvl_prev_r <= lvl;
        end
    end

    // ring counts only the pin going low to high
    always_comb begin
        evt.cts = lvl.cts ^ lvl_prev_r.cts;
        evt.dsr = lvl.dsr ^ lvl_prev_r.dsr;
        evt.cd = lvl.cd ^ lvl_prev_r.cd;
        evt.ri = lvl_prev_r.ri && !lvl.ri;
    end

    // change flags: a read clears, a same-cycle event still sets
    always_comb begin
        delta_nxt = rd_stat ? 4'h0 : delta_r;
        delta_nxt = delta_nxt | evt;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            delta_r <= 4'h0;
        end else begin
            delta_r <= delta_nxt;
        end
    end

    // status byte as software sees it
    assign msr_view = {lvl.cd, lvl.ri, lvl.dsr, lvl.cts,
                       delta_r};

    // gpio level view hides pins taken by the modem
    assign o_io_pin_view = i_io_modem_sel ? 4'h0 :
        {!pin_s2_r.ri_n, !pin_s2_r.cd_n, 1'b0, !pin_s2_r.dsr_n};

    // sticky interrupt status, write one clears, set wins
    always_comb begin
        irq_stat_nxt = irq_stat_r;
        if (wr_istat) begin
            irq_stat_nxt = irq_stat_r & ~i_bus.wdata[3:0];
        end
        irq_stat_nxt = irq_stat_nxt | evt;
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            irq_stat_r <= umc_pkg::IRQ_RESET;
        end else begin
            irq_stat_r <= irq_stat_nxt;
        end
    end

    // interrupt mask
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            irq_mask_r <= umc_pkg::IRQ_RESET;
        end else if (wr_imask) begin
            irq_mask_r <= i_bus.wdata[3:0];
        end
    end

    // level interrupt, registered to keep glitches off the pin
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(irq_stat_nxt & irq_mask_r);
        end
    end

    // read data for exactly one cycle after the strobe
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_rdata <= umc_pkg::RDATA_IDLE;
        end else if (i_bus.rd) begin
            case (i_bus.addr)
                umc_pkg::ADDR_MODEM_CTL: o_rdata <= ctl_r;
                umc_pkg::ADDR_MODEM_STAT: o_rdata <= msr_view;
                umc_pkg::ADDR_SCRATCH: o_rdata <= scratch_r;
                umc_pkg::ADDR_IRQ_STAT: o_rdata <= {4'h0, irq_stat_r};
                umc_pkg::ADDR_IRQ_MASK: o_rdata <= {4'h0, irq_mask_r};
                // unmapped reads answer zero
                default: o_rdata <= umc_pkg::RDATA_IDLE;
            endcase
        end else begin
            o_rdata <= umc_pkg::RDATA_IDLE;
        end
    end

    // modem outputs; held inactive in loopback so the line is quiet, o_dtr_n only while i_io_modem_sel
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_rts_n <= 1'b1;
            o_dtr_n <= 1'b1;
        end else begin
            if (loop) begin
                o_rts_n <= 1'b1;
            end else if (i_auto_rts_en) begin
                o_rts_n <= i_flow_rts_n;
            end else begin
                o_rts_n <= !ctl_r[umc_pkg::CTL_RTS];
            end
            // gpio level register cannot reach a modem-owned pin
            if (!i_io_modem_sel) begin
                o_dtr_n <= i_gpio5_level;
            end else if (loop) begin
                o_dtr_n <= 1'b1;
            end else begin
                o_dtr_n <= !ctl_r[umc_pkg::CTL_DTR];
            end
        end
    end

    // serial path: loopback joins tx to rx inside the chip
    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            o_tx_pin <= 1'b1;
            o_rx_serial <= 1'b1;
        end else begin
            o_tx_pin <= loop ? 1'b1 : i_tx_serial;
            o_rx_serial <= loop ? i_tx_serial : rx_s2_r;
        end
    end

    // checks
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);

    property p_div1;
        !ctl_r[umc_pkg::CTL_PRESCALE] |-> o_clk_en;
    endproperty
    a_div1: assert property (p_div1)
        else $error("undivided clock enable missing");

    property p_div4_gap;
        (ctl_r[umc_pkg::CTL_PRESCALE] && o_clk_en && !wr_ctl)
            |=> !o_clk_en;
    endproperty
    a_div4_gap: assert property (p_div4_gap)
        else $error("prescaled enable not spaced");

    property p_efr_lock;
        (wr_ctl && !i_efr_wr_en)
            |=> ((ctl_r & umc_pkg::CTL_LOCKED_MASK)
                 == ($past(ctl_r) & umc_pkg::CTL_LOCKED_MASK));
    endproperty
    a_efr_lock: assert property (p_efr_lock)
        else $error("locked control bits changed");

    property p_loop_status;
        loop |-> (msr_view[4] == ctl_r[umc_pkg::CTL_RTS])
              && (msr_view[5] == ctl_r[umc_pkg::CTL_DTR]);
    endproperty
    a_loop_status: assert property (p_loop_status)
        else $error("loopback status bits wrong");

    property p_rts_manual;
        (!loop && !i_auto_rts_en)
            |=> o_rts_n == !$past(ctl_r[umc_pkg::CTL_RTS]);
    endproperty
    a_rts_manual: assert property (p_rts_manual)
        else $error("request-to-send not following bit 1");

    property p_rts_auto;
        (!loop && i_auto_rts_en) |=> o_rts_n == $past(i_flow_rts_n);
    endproperty
    a_rts_auto: assert property (p_rts_auto)
        else $error("request-to-send not from flow control");

    property p_read_clear;
        (rd_stat && evt == 4'h0) |=> delta_r == 4'h0;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("change flags not cleared by read");

    property p_set_wins;
        evt.cts |=> delta_r[0] && irq_stat_r[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("change event lost");

    property p_cts_pin;
        !loop |-> msr_view[4] == !pin_s2_r.cts_n;
    endproperty
    a_cts_pin: assert property (p_cts_pin)
        else $error("status bit 4 not inverse of pin");

    property p_scratch;
        wr_scr ##1 (i_bus.rd && hit(i_bus.addr, umc_pkg::ADDR_SCRATCH))
            |=> o_rdata == $past(i_bus.wdata, 2);
    endproperty
    a_scratch: assert property (p_scratch)
        else $error("scratch byte read back wrong");

    property p_msr_read;
        rd_stat |=> o_rdata == $past(msr_view);
    endproperty
    a_msr_read: assert property (p_msr_read)
        else $error("status read data wrong");

    property p_dtr_manual;
        (i_io_modem_sel && !loop)
            |=> o_dtr_n == !$past(ctl_r[umc_pkg::CTL_DTR]);
    endproperty
    a_dtr_manual: assert property (p_dtr_manual)
        else $error("terminal-ready not following bit 0");

    property p_loop_serial;
        loop |=> o_tx_pin && (o_rx_serial == $past(i_tx_serial));
    endproperty
    a_loop_serial: assert property (p_loop_serial)
        else $error("loopback serial path wrong");

    property p_ring_rise;
        (lvl_prev_r.ri && !lvl.ri) |=> delta_r[2];
    endproperty
    a_ring_rise: assert property (p_ring_rise)
        else $error("ring end not latched");

    property p_ring_fall;
        (!delta_r[2] && !lvl_prev_r.ri && lvl.ri) |=> !delta_r[2];
    endproperty
    a_ring_fall: assert property (p_ring_fall)
        else $error("ring start wrongly latched");

    property p_scratch_only;
        wr_scr |=> (ctl_r == $past(ctl_r))
               && (irq_mask_r == $past(irq_mask_r));
    endproperty
    a_scratch_only: assert property (p_scratch_only)
        else $error("scratch write disturbed other state");

endmodule : umc_modem_ctl

//--- tb/umc_modem_peer.sv
`timescale 1ns/100ps
// far-side modem: turns the bench's wishes into active-low lines
module umc_modem_peer (
    // clock
    input wire logic i_core_clk,
    // lines to assert, active high, {cd,ri,dsr,cts}
    input wire logic [3:0] i_assert,
    // modem lines toward the uart
    output umc_pkg::umc_modem_in_s o_modem_n
);
    // lines idle high, as a real modem at rest
    initial o_modem_n = '1;
    // asserted means low on the wire
    always @(posedge i_core_clk) begin
        o_modem_n <= ~i_assert;
    end
endmodule : umc_modem_peer

//--- tb/uart_modem_control_status_tb_top.sv
`timescale 1ns/100ps
module uart_modem_control_status_tb_top;
    // clock, reset, register port
    logic clk = 1'b0;
    logic rst = 1'b1;
    umc_pkg::umc_bus_req_s bus = '0;
    // side inputs
    logic enhanced_feature_ctl = 1'b0, auto_rts = 1'b0, flow_rts_n = 1'b1;
    logic tx_ser = 1'b1, modem_sel = 1'b0, gpio5 = 1'b0;
    logic rx_pin = 1'b1;
    logic [3:0] want = 4'h0;
    umc_pkg::umc_modem_in_s modem_n;
    // outputs
    logic [7:0] rdata;
    logic rts_n, dtr_n, tx_pin, rx_ser, clk_en, irda, xon, loop;
    logic trig, irq;
    logic [3:0] pin_view;
    // notes of expected reads, {mask, value}
    logic [15:0] note_q[$];
    logic [15:0] note;
    logic rd_seen = 1'b0;
    logic [7:0] cnt;
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h6d4adc1c;

    always #12.5 clk = ~clk;

    umc_modem_peer peer (.i_core_clk(clk), .i_assert(want),
        .o_modem_n(modem_n));

    umc_modem_ctl #(.PRESCALE_DIV(4)) dut (.i_core_clk(clk),
        .i_reset(rst), .i_bus(bus), .o_rdata(rdata), .i_efr_wr_en(enhanced_feature_ctl),
        .i_auto_rts_en(auto_rts), .i_flow_rts_n(flow_rts_n),
        .i_tx_serial(tx_ser), .i_io_modem_sel(modem_sel),
        .i_gpio5_level(gpio5), .i_modem_n(modem_n), .i_rx_pin(rx_pin),
        .o_rts_n(rts_n), .o_dtr_n(dtr_n), .o_tx_pin(tx_pin),
        .o_rx_serial(rx_ser), .o_clk_en(clk_en), .o_irda_mode(irda),
        .o_xon_any(xon), .o_loopback(loop), .o_trig_access_en(trig),
        .o_io_pin_view(pin_view), .o_irq(irq));

    // small xorshift, fixed seed keeps runs repeatable
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        s = s ^ (s << 5);
        return s;
    endfunction : xs

    // one comparison, four-state exact
    task automatic chk(input string what, input logic [7:0] exp, got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask : chk

    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up

    // one-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask : wr

    // one-cycle read strobe, expectation noted for the monitor
    task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
        @(posedge clk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        note_q.push_back({m, e & m});
    endtask : rd

    // drop strobes for n cycles, ends just after a rising edge
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            bus <= '0;
        end
    endtask : idle

    // bounded wait for the interrupt level
    task automatic wait_irq(input logic e);
        int k;
        k = 0;
        while (irq !== e && k < 12) begin
            @(negedge clk);
            k++;
        end
        // a miss is counted by the compare, then the run ends
        chk("irq", {7'h00, e}, {7'h00, irq});
        if (irq !== e) begin
            wrap_up();
        end
    endtask : wait_irq

    // read data stands one cycle after the strobe only
    always @(posedge clk) rd_seen <= bus.rd & ~rst;
    always @(negedge clk) begin
        if (rd_seen) begin
            note = note_q.pop_front();
            chk("rdata", note[7:0], rdata & note[15:8]);
        end
    end

    // main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // reset state and an unmapped place
        rd(umc_pkg::ADDR_MODEM_CTL, umc_pkg::CTL_RESET, 8'hff);
        rd(umc_pkg::ADDR_MODEM_STAT, 8'h00, 8'hff);
        rd(umc_pkg::ADDR_SCRATCH, umc_pkg::SCRATCH_RESET, 8'hff);
        rd(4'hf, umc_pkg::RDATA_IDLE, 8'hff);
        // scratch, back to back with random bytes
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            wr(umc_pkg::ADDR_SCRATCH, seed[7:0]);
            rd(umc_pkg::ADDR_SCRATCH, seed[7:0], 8'hff);
        end
        wr(4'hf, 8'h5a);
        rd(umc_pkg::ADDR_SCRATCH, seed[7:0], 8'hff);
        // locked bits refused without the enhanced enable
        wr(umc_pkg::ADDR_MODEM_CTL, 8'hff);
        rd(umc_pkg::ADDR_MODEM_CTL, 8'h13, 8'hff);
        rd(umc_pkg::ADDR_MODEM_STAT, 8'h30, 8'h30);
        // loopback: tx comes back, tx pin silent
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            idle(1);
            tx_ser <= seed[0];
            idle(1);
            @(negedge clk);
            chk("rx_ser", {7'h00, seed[0]}, {7'h00, rx_ser});
            chk("tx_pin", 8'h01, {7'h00, tx_pin});
        end
        idle(1);
        enhanced_feature_ctl <= 1'b1;
        wr(umc_pkg::ADDR_MODEM_CTL, 8'hf4);
        rd(umc_pkg::ADDR_MODEM_CTL, 8'hf4, 8'hff);
        idle(2);
        @(negedge clk);
        chk("mode", 8'h0f, {4'h0, irda, xon, loop, trig});
        cnt = 8'h00;
        repeat (16) begin
            @(negedge clk);
            cnt = cnt + {7'h00, clk_en};
        end
        chk("clk_en", 8'h04, cnt);
        idle(1);
        enhanced_feature_ctl <= 1'b0;
        wr(umc_pkg::ADDR_MODEM_CTL, 8'h00);
        rd(umc_pkg::ADDR_MODEM_CTL, 8'he4, 8'hff);
        idle(1);
        enhanced_feature_ctl <= 1'b1;
        wr(umc_pkg::ADDR_MODEM_CTL, 8'h02);
        rd(umc_pkg::ADDR_MODEM_STAT, 8'h00, 8'h00);
        idle(3);
        cnt = 8'h00;
        repeat (8) begin
            @(negedge clk);
            cnt = cnt + {7'h00, clk_en};
        end
        chk("clk_en", 8'h08, cnt);
        chk("rts_n", 8'h00, {7'h00, rts_n});
        // flow logic takes over the request-to-send pin
        idle(1);
        auto_rts <= 1'b1;
        idle(2);
        @(negedge clk);
        chk("rts_n", 8'h01, {7'h00, rts_n});
        idle(1);
        flow_rts_n <= 1'b0;
        idle(2);
        @(negedge clk);
        chk("rts_n", 8'h00, {7'h00, rts_n});
        idle(1);
        flow_rts_n <= 1'b1;
        auto_rts <= 1'b0;
        modem_sel <= 1'b1;
        gpio5 <= 1'b1;
        wr(umc_pkg::ADDR_MODEM_CTL, 8'h01);
        idle(3);
        @(negedge clk);
        chk("dtr_n", 8'h00, {7'h00, dtr_n});
        idle(1);
        modem_sel <= 1'b0;
        idle(2);
        @(negedge clk);
        chk("dtr_n", 8'h01, {7'h00, dtr_n});
        // status levels and change flags
        idle(1);
        modem_sel <= 1'b1;
        want <= 4'hf;
        idle(6);
        rd(umc_pkg::ADDR_MODEM_STAT, 8'hfb, 8'hff);
        rd(umc_pkg::ADDR_MODEM_STAT, 8'hf0, 8'hff);
        idle(1);
        want <= 4'h0;
        idle(6);
        rd(umc_pkg::ADDR_MODEM_STAT, 8'h0f, 8'hff);
        rd(umc_pkg::ADDR_MODEM_STAT, 8'h00, 8'hff);
        // interrupt raised, cleared, then masked
        wr(umc_pkg::ADDR_IRQ_STAT, 8'h0f);
        wr(umc_pkg::ADDR_IRQ_MASK, 8'h01);
        idle(1);
        want <= 4'h1;
        wait_irq(1'b1);
        rd(umc_pkg::ADDR_IRQ_STAT, 8'h01, 8'h0f);
        wr(umc_pkg::ADDR_IRQ_STAT, 8'h01);
        idle(1);
        wait_irq(1'b0);
        wr(umc_pkg::ADDR_IRQ_MASK, 8'h00);
        idle(1);
        want <= 4'h0;
        idle(6);
        @(negedge clk);
        chk("irq", 8'h00, {7'h00, irq});
        rd(umc_pkg::ADDR_IRQ_STAT, 8'h01, 8'h0f);
        // pin view hidden while the modem owns the pins
        want <= 4'hf;
        idle(6);
        @(negedge clk);
        chk("pin_view", 8'h00, {4'h0, pin_view});
        idle(1);
        modem_sel <= 1'b0;
        @(negedge clk);
        chk("pin_view", 8'h0d, {4'h0, pin_view});
        rd(umc_pkg::ADDR_MODEM_STAT, 8'h10, 8'hf0);
        // serial path outside loopback, random levels
        seed = xs(seed);
        tx_ser <= seed[1];
        rx_pin <= seed[2];
        idle(3);
        @(negedge clk);
        chk("tx_pin", {7'h00, seed[1]}, {7'h00, tx_pin});
        chk("rx_ser", {7'h00, seed[2]}, {7'h00, rx_ser});
        idle(3);
        wrap_up();
    end
endmodule : uart_modem_control_status_tb_top
